// [logic/lcd_serial_ctrl.sv]
// Serial control receiver and output control of a segment LCD driver.
// Assumes slow link pins (shift clock well under ref_clk / 4) and an
// APB master on ref_clk.
//
// Functional notes
// - frame opens with eight-bit address 44h
// - sample on shift rise, commit on enable fall
// - wrong bit count keeps old register state
// - shift clock may idle high between transfers
// - forced off grounds every port, segment, common
// - forced off stops oscillator, ignores external clock
// - forced off still accepts and commits transfers
// - last segment pin grounded unless enable set
// - clock source bit picks internal or external
// - shared pins act as segments or ports
// - port field decodes zero to four ports
// - shared commons follow the drive-type field
// - drive type sets duty and common count
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_params.svh"

module lcd_serial_ctrl (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // Serial link pins
  input  wire logic                chip_enable,
  input  wire logic                serial_shift_clock,
  input  wire logic                serial_data_in,
  input  wire logic                display_force_off_n,
  input  wire logic                external_clock_in,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Pin control and core clock
  output var  lcd_pkg::lcd_pins_t  pins,
  output var  logic                osc_run,
  output var  logic                core_tick
);
  import lcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [4:0] pin_s;        // Synchronised pins
  logic       ce_s;         // Chip enable
  logic       sck_s;        // Shift clock
  logic       sdi_s;        // Data
  logic       foff_n_s;     // Force-off, low active
  logic       ext_s;        // External clock

  lcd_sync #(.W(5)) u_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in ({external_clock_in, display_force_off_n,
                serial_data_in, serial_shift_clock, chip_enable}),
    .sync_out (pin_s)
  );
  assign {ext_s, foff_n_s, sdi_s, sck_s, ce_s} = pin_s;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins
  logic ce_q;               // Previous chip enable
  logic sck_q;              // Previous shift clock
  logic ext_q;              // Previous external clock
  logic ce_rise;
  logic ce_fall;
  logic sck_rise;
  logic ext_rise;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ce_q  <= 1'b0;
      sck_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      ce_q  <= ce_s;
      sck_q <= sck_s;
      ext_q <= ext_s;
    end
  end

  // Only rising shift edges count, so a clock that idles high makes no
  // false bit at either end of the enable window
  assign ce_rise  = ce_s & ~ce_q;
  assign ce_fall  = ~ce_s & ce_q;
  assign sck_rise = sck_s & ~sck_q;
  assign ext_rise = ext_s & ~ext_q;

  ////////////////////////////////////////////////////////////////////////
  // Receiver: address while enable low, data while enable high
  lcd_rx_state_t                 state,    next_state;
  logic [7:0]                    addr,     next_addr;
  logic                          match,    next_match;
  logic [6:0]                    cnt,      next_cnt;
  logic [`LCD_FRAME_W-1:0]       shift,    next_shift;
  logic [`LCD_FRAME_W-1:0]       disp,     next_disp;
  lcd_cfg_t                      cfg,      next_cfg;
  lcd_result_t                   result,   next_result;
  logic [7:0]                    ok_cnt,   next_ok_cnt;
  logic [7:0]                    bad_cnt,  next_bad_cnt;
  logic                          rx_enable;  // From APB control

  always_comb
  begin
    next_state   = state;
    next_addr    = addr;
    next_match   = match;
    next_cnt     = cnt;
    next_shift   = shift;
    next_disp    = disp;
    next_cfg     = cfg;
    next_result  = result;
    next_ok_cnt  = ok_cnt;
    next_bad_cnt = bad_cnt;
    case (state)
      LCD_RX_ADDR:
      begin
        // Address goes in first bit as LSB
        if (sck_rise)
          next_addr = {sdi_s, addr[7:1]};
        if (ce_rise)
        begin
          next_state = LCD_RX_DATA;
          next_match = (addr == `LCD_DEV_ADDR) && rx_enable;
          next_cnt   = '0;
        end
      end
      LCD_RX_DATA:
      begin
        // Bits are taken regardless of force-off
        if (sck_rise)
        begin
          next_shift = {sdi_s, shift[`LCD_FRAME_W-1:1]};
          if (cnt != `LCD_CNT_MAX)
            next_cnt = cnt + 7'h01;  // Saturates at 127, never wraps to 0
        end
        if (ce_fall)
        begin
          next_state = LCD_RX_ADDR;
          if (!match)
            next_state = LCD_RX_ADDR;
          else if (cnt == `LCD_LONG_BITS)
          begin
            next_disp   = shift;
            next_result = LCD_RES_DISP;
            next_ok_cnt = ok_cnt + 8'h01;
          end
          else if (cnt == `LCD_SHORT_BITS)
          begin
            next_cfg.port_select_field =
              {shift[`LCD_SHORT_BASE + `LCD_FLD_PORT0],
               shift[`LCD_SHORT_BASE + `LCD_FLD_PORT1],
               shift[`LCD_SHORT_BASE + `LCD_FLD_PORT2]};
            next_cfg.drive_type_bit0     =
              shift[`LCD_SHORT_BASE + `LCD_FLD_DRV0];
            next_cfg.drive_type_bit1     =
              shift[`LCD_SHORT_BASE + `LCD_FLD_DRV1];
            next_cfg.last_segment_enable =
              shift[`LCD_SHORT_BASE + `LCD_FLD_LSEG];
            next_cfg.clock_source_select =
              shift[`LCD_SHORT_BASE + `LCD_FLD_CSRC];
            next_result = LCD_RES_CFG;
            next_ok_cnt = ok_cnt + 8'h01;
          end
          else
          begin
            // Old state is kept; only the error count and the result move
            next_result  = LCD_RES_BAD;
            next_bad_cnt = bad_cnt + 8'h01;
          end
        end
      end
      default: next_state = LCD_RX_ADDR;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state   <= LCD_RX_ADDR;
      addr    <= '0;
      match   <= 1'b0;
      cnt     <= '0;
      shift   <= '0;
      disp    <= '0;
      cfg     <= `LCD_CFG_RST;
      result  <= LCD_RES_NONE;
      ok_cnt  <= '0;
      bad_cnt <= '0;
    end
    else
    begin
      state   <= next_state;
      addr    <= next_addr;
      match   <= next_match;
      cnt     <= next_cnt;
      shift   <= next_shift;
      disp    <= next_disp;
      cfg     <= next_cfg;
      result  <= next_result;
      ok_cnt  <= next_ok_cnt;
      bad_cnt <= next_bad_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core clock: divided ref_clk or synchronised external clock edges
  logic [7:0] osc_div, next_osc_div;
  logic       next_osc_run;
  logic       next_core_tick;

  always_comb
  begin
    next_osc_run   = foff_n_s && !cfg.clock_source_select;
    next_osc_div   = '0;   // Held at zero: oscillator stopped
    next_core_tick = 1'b0;
    if (next_osc_run)
    begin
      next_osc_div = (osc_div == `LCD_OSC_DIV - 8'h01)
                     ? 8'h00 : osc_div + 8'h01;
      next_core_tick = (osc_div == `LCD_OSC_DIV - 8'h01);
    end
    else if (foff_n_s)
      next_core_tick = ext_rise;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      osc_div   <= '0;
      osc_run   <= 1'b0;
      core_tick <= 1'b0;
    end
    else
    begin
      osc_div   <= next_osc_div;
      osc_run   <= next_osc_run;
      core_tick <= next_core_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin functions, registered so the outputs leave from flops
  lcd_pins_t  next_pins;
  logic [3:0] disp_ports;

  // Port levels come from every third display bit
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_port
      assign disp_ports[gp] = disp[gp * `LCD_PORT_STRIDE];
    end
  endgenerate

  lcd_pin_decode u_dec (
    .force_off_n (foff_n_s),
    .cfg         (cfg),
    .disp_ports  (disp_ports),
    .pins        (next_pins)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      pins <= '0;   // Grounded until reset ends and force-off is released
    else
      pins <= next_pins;
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, read data registered with pready
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_rx_enable;
  logic        access;

  assign access = psel && penable;

  always_comb
  begin
    next_prdata    = prdata;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_rx_enable = rx_enable;
    if (access && !pready)
    begin
      next_pready = 1'b1;
      case (paddr)
        `LCD_REG_CTRL:   next_prdata = {31'h0000_0000, rx_enable};
        `LCD_REG_STATUS: next_prdata = {20'h0_0000, foff_n_s,
                                        state == LCD_RX_DATA,
                                        result, 1'b0, cfg};
        `LCD_REG_COUNT:  next_prdata = {16'h0000, bad_cnt, ok_cnt};
        `LCD_REG_DISP0:  next_prdata = disp[31:0];
        default:
        begin
          next_prdata  = 32'h0000_0000;
          next_pslverr = 1'b1;     // Unmapped address
        end
      endcase
    end
    // Write lands at the edge that samples pready high
    if (access && pready && pwrite && paddr == `LCD_REG_CTRL)
      next_rx_enable = pwdata[0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      rx_enable <= `LCD_CTRL_RST;
    end
    else
    begin
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      rx_enable <= next_rx_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic end_frame;
  assign end_frame = (state == LCD_RX_DATA) && ce_fall;

  property p_ground;
    !foff_n_s |=> (pins == '0) && !osc_run;
  endproperty
  a_ground: assert property (p_ground)
    else $error("pins not grounded while forced off");

  property p_no_clock_off;
    !foff_n_s [*2] |=> !core_tick;
  endproperty
  a_no_clock_off: assert property (p_no_clock_off)
    else $error("core tick while forced off");

  property p_foreign;
    end_frame && !match |=> $stable(cfg) && $stable(disp);
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign address changed state");

  property p_badcount;
    end_frame && cnt != `LCD_LONG_BITS && cnt != `LCD_SHORT_BITS
      |=> $stable(cfg) && $stable(disp) && result == LCD_RES_BAD
          || !$past(match);
  endproperty
  a_badcount: assert property (p_badcount)
    else $error("bad length frame executed");

  property p_commit_long;
    end_frame && match && cnt == `LCD_LONG_BITS
      |=> disp == $past(shift) ##1 pins.port_level ==
          ($past(pins.port_mode) & disp_ports) || !$past(foff_n_s);
  endproperty
  a_commit_long: assert property (p_commit_long)
    else $error("long frame not committed");

  property p_commit_off;
    end_frame && match && cnt == `LCD_SHORT_BITS && !foff_n_s
      |=> result == LCD_RES_CFG &&
          cfg.last_segment_enable == $past(shift[53]);
  endproperty
  a_commit_off: assert property (p_commit_off)
    else $error("config not taken while forced off");

  property p_last_seg;
    foff_n_s && !cfg.last_segment_enable |=> !pins.last_seg_drive;
  endproperty
  a_last_seg: assert property (p_last_seg)
    else $error("last segment pin not grounded");

  property p_ext_clock;
    foff_n_s && cfg.clock_source_select && ext_rise |=> core_tick;
  endproperty
  a_ext_clock: assert property (p_ext_clock)
    else $error("external edge not passed to core");

  property p_ports;
    foff_n_s && cfg.port_select_field == 3'h4
      |=> pins.port_mode == 4'hF;
  endproperty
  a_ports: assert property (p_ports)
    else $error("all-port decode wrong");

  property p_static;
    foff_n_s && cfg.drive_type_bit0 && cfg.drive_type_bit1
      |=> pins.common_mode == 3'h0;
  endproperty
  a_static: assert property (p_static)
    else $error("static drive left commons active");

  c_long:  cover property (end_frame && match && cnt == `LCD_LONG_BITS);
  c_short: cover property (end_frame && match && cnt == `LCD_SHORT_BITS);
  c_bad:   cover property (end_frame && match && cnt == 7'h2F);
  c_ext:   cover property (foff_n_s && cfg.clock_source_select
                           && ext_rise);

endmodule : lcd_serial_ctrl
`default_nettype wire

// [logic/lcd_params.svh]
// Constants for the segment LCD driver serial control block.
// Assumes inclusion by bare name from logic/ sources only.
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH

// Serial frame
`define LCD_DEV_ADDR        8'h44
`define LCD_LONG_BITS       7'h60
`define LCD_SHORT_BITS      7'h30
`define LCD_CNT_MAX         7'h7F
`define LCD_FRAME_W         96

// Control field positions inside a short frame (first bit = 0)
`define LCD_SHORT_BASE      48
`define LCD_FLD_PORT0       0
`define LCD_FLD_PORT1       1
`define LCD_FLD_PORT2       2
`define LCD_FLD_DRV0        3
`define LCD_FLD_DRV1        4
`define LCD_FLD_LSEG        5
`define LCD_FLD_CSRC        6

// Display data positions of the four port levels
`define LCD_PORT_STRIDE     3

// Internal oscillator divider, in ref_clk cycles per core tick
`define LCD_OSC_DIV         8'h08

// APB register byte offsets
`define LCD_REG_CTRL        12'h000
`define LCD_REG_STATUS      12'h004
`define LCD_REG_COUNT       12'h008
`define LCD_REG_DISP0       12'h00C

// Reset values
`define LCD_CTRL_RST        1'b1
`define LCD_CFG_RST         7'h00

`endif

// [logic/lcd_pkg.sv]
// Types shared by the LCD serial control block.
// Assumes lcd_params.svh constants for all numeric values.
`default_nettype none
package lcd_pkg;

  // Configuration received over the serial link
  typedef struct packed {
    logic       clock_source_select;  // 0 internal osc, 1 external
    logic       last_segment_enable;  // 0 pin grounded
    logic       drive_type_bit1;
    logic       drive_type_bit0;
    logic [2:0] port_select_field;    // First frame bit lands in MSB
  } lcd_cfg_t;

  // Pin function and level view of the shared output pins
  typedef struct packed {
    logic       drive_enable;     // 0 while every pin is grounded
    logic [3:0] port_mode;        // shared_seg_port_N acts as port
    logic [3:0] port_level;       // level of pins in port mode
    logic [2:0] common_mode;      // shared_common_2..4 acts as common
    logic       last_seg_drive;   // last_segment_pin drives segment
  } lcd_pins_t;

  // Outcome of the last completed frame
  typedef enum logic [1:0] {
    LCD_RES_NONE,
    LCD_RES_DISP,
    LCD_RES_CFG,
    LCD_RES_BAD
  } lcd_result_t;

  // Receiver states
  typedef enum logic {
    LCD_RX_ADDR,
    LCD_RX_DATA
  } lcd_rx_state_t;

endpackage : lcd_pkg
`default_nettype wire

// [logic/lcd_sync.sv]
// Two-flop synchroniser bank for pins entering the ref_clk domain.
// Assumes asynchronous, slow inputs; output is two edges late.
`timescale 1ns/10ps
`default_nettype none

module lcd_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  import lcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // One pair of flops per bit; the first flop feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic stage1;  // Metastability catcher
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          stage1        <= 1'b0;
          sync_out[gi]  <= 1'b0;
        end
        else
        begin
          stage1        <= async_in[gi];
          sync_out[gi]  <= stage1;
        end
      end
    end
  endgenerate

endmodule : lcd_sync
`default_nettype wire

// [logic/lcd_pin_decode.sv]
// Decodes configuration into the function of each shared pin.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/10ps
`default_nettype none

module lcd_pin_decode (
  input  wire logic             force_off_n,
  input  wire lcd_pkg::lcd_cfg_t cfg,
  input  wire logic [3:0]       disp_ports,
  output var  lcd_pkg::lcd_pins_t pins
);
  import lcd_pkg::*;

  // Number of shared pins turned into ports
  function automatic logic [2:0] port_count(input logic [2:0] sel);
    case (sel)
      3'h1:    port_count = 3'h1;
      3'h2:    port_count = 3'h2;
      3'h3:    port_count = 3'h3;
      3'h4:    port_count = 3'h4;
      default: port_count = 3'h0;  // 101..111 leave all as segments
    endcase
  endfunction : port_count

  // Number of common lines in use: 4 - bit0 - 2*bit1
  function automatic logic [2:0] common_count(input logic b0,
                                              input logic b1);
    case ({b1, b0})
      2'h0:    common_count = 3'h4;
      2'h1:    common_count = 3'h3;
      2'h2:    common_count = 3'h2;
      default: common_count = 3'h1;
    endcase
  endfunction : common_count

  ////////////////////////////////////////////////////////////////////////
  // Everything reads zero while forced off so every pin sits at ground
  always_comb
  begin
    logic [2:0] np;
    logic [2:0] nc;
    np   = port_count(cfg.port_select_field);
    nc   = common_count(cfg.drive_type_bit0,
                        cfg.drive_type_bit1);
    pins = '0;
    if (force_off_n)
    begin
      pins.drive_enable = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        pins.port_mode[i]  = (3'(i) < np);
        pins.port_level[i] = (3'(i) < np) && disp_ports[i];
      end
      for (int k = 0; k < 3; k++)
        pins.common_mode[k] = (3'(k + 1) < nc);
      pins.last_seg_drive = cfg.last_segment_enable;
    end
  end

endmodule : lcd_pin_decode
`default_nettype wire

// [bench/lcd_link_model.sv]
// Link model: the system controller side of the three-wire serial link.
// Assumes ref_clk as time base; one link half period is 10 cycles.
`timescale 1ns/10ps
`default_nettype none

module lcd_link_model (
  input  wire logic ref_clk,
  output var  logic chip_enable,
  output var  logic serial_shift_clock,
  output var  logic serial_data_in
);
  logic busy;  // Frame in progress

  // Pins idle at time zero
  initial
  begin
    chip_enable = 1'b0;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
    busy = 1'b0;
  end

  // Released data line toggles, so a stale level never looks like data
  always @(posedge ref_clk)
    if (!busy) serial_data_in <= ~serial_data_in;

  // Half a link period, 80 ns
  task automatic half();
    repeat (10) @(posedge ref_clk);
  endtask : half

  // One bit: data set while the shift clock is low, taken on its rise
  task automatic bit_out(input logic b);
    serial_shift_clock <= 1'b0;
    serial_data_in <= b;
    half();
    serial_shift_clock <= 1'b1;
    half();
  endtask : bit_out

  // Whole frame: address with enable low, then n data bits
  task automatic send(input logic [7:0] adr, input int n,
                      input logic [95:0] d, input logic hi);
    busy = 1'b1;
    serial_shift_clock <= hi;  // Idle level chosen per frame
    half();
    for (int i = 0; i < 8; i++) bit_out(adr[i]);  // LSB first
    serial_shift_clock <= hi;
    half();
    chip_enable <= 1'b1;
    half();
    for (int i = 0; i < n; i++) bit_out(d[i]);  // Data after address
    serial_shift_clock <= hi;  // Clock stands still before enable falls
    half();
    chip_enable <= 1'b0;
    half();
    busy = 1'b0;
  endtask : send
endmodule : lcd_link_model
`default_nettype wire

// [bench/lcd_driver_serial_control_tb.sv]
// Testbench of the LCD serial control block: APB and link stimulus,
// expectations queued and checked by one output monitor.
// Assumes lcd_pkg, the design and the link model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module lcd_driver_serial_control_tb;
  import lcd_pkg::*;
  logic        ref_clk, nrst, fon, ext_clk, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, osc_run, core_tick, ce, sck, sdi;
  logic        snap = 1'b0;      // Pin snapshot request
  logic        tk = 1'b0;        // Core ticks seen in the last window
  lcd_pins_t   pins;
  logic [32:0] q[$];             // Expected results, oldest first
  logic [32:0] got;
  logic [15:0] rs = 16'h0057;    // Random state, seeded with 87
  int          n_fail, cmp_count, ticks, cyc;

  lcd_link_model i_link (.ref_clk(ref_clk), .chip_enable(ce),
    .serial_shift_clock(sck), .serial_data_in(sdi));
  lcd_serial_ctrl i_dut (.ref_clk(ref_clk), .nrst(nrst), .chip_enable(ce),
    .serial_shift_clock(sck), .serial_data_in(sdi),
    .display_force_off_n(fon), .external_clock_in(ext_clk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .osc_run(osc_run),
    .core_tick(core_tick));

  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  // External clock of 24 cycles, tick count, hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 12 == 11) ext_clk <= ~ext_clk;
    if (core_tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // Monitor: each read answer or snapshot takes the oldest note
  always @(posedge ref_clk)
    if ((pready === 1'b1 && !pwrite) || snap)
    begin
      got = snap ? {18'h0, tk, osc_run, pins} : {pslverr, prdata};
      cmp_count++;
      if (q.size() == 0 || got !== q[0])
        $display("[FAIL] t=%0t exp=%h got=%h", $time,
                 q.size() ? q[0] : 'x, got);
      if (q.size() == 0 || got !== q[0]) n_fail++;
      if (q.size() != 0) void'(q.pop_front());
    end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Status word: config, last result, force-off pin
  function automatic logic [32:0] st(input logic [6:0] c,
                                     input logic [1:0] r);
    return {1'b0, 20'h0, fon, 1'b0, r, 1'b0, c};
  endfunction : st

  // Expected {ticking, osc_run, pins} for a config and port levels
  function automatic logic [14:0] pe(input logic [6:0] c,
                                     input logic [3:0] lv, input logic on);
    logic [3:0] pm;
    logic [2:0] cm;
    case (c[2:0])
      3'h1: pm = 4'h1;
      3'h2: pm = 4'h3;
      3'h3: pm = 4'h7;
      3'h4: pm = 4'hF;
      default: pm = 4'h0;  // Codes above four give segments
    endcase
    case (c[4:3])
      2'h0: cm = 3'h7;
      2'h1: cm = 3'h3;
      2'h2: cm = 3'h1;
      default: cm = 3'h0;
    endcase
    return on ? {1'b1, ~c[6], 1'b1, pm, lv, cm, c[5]} : 15'h0;
  endfunction : pe

  // Config frame: seven control bits, random filler
  function automatic logic [95:0] fr(input logic [6:0] c);
    logic [95:0] v;
    v = {6{rs}};
    v[6:0] = {c[6:3], c[0], c[1], c[2]};
    return v;
  endfunction : fr

  // APB transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    if (!w) q.push_back(e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pin snapshot after a settle time and a tick window
  task automatic chk(input logic [14:0] e);
    int t0;
    repeat (8) @(posedge ref_clk);
    t0 = ticks;
    repeat (100) @(posedge ref_clk);
    tk = (ticks != t0);
    q.push_back({18'h0, e});
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
  endtask : chk

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [6:0]  c;
    logic [95:0] d;
    ref_clk = 1'b0;
    nrst = 1'b0;
    fon = 1'b0;
    ext_clk = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(0, 12'h000, 0, 33'h1);
    apb(0, 12'h004, 0, st(0, 0));
    apb(0, 12'h008, 0, 33'h0);
    apb(0, 12'h010, 0, 33'h1_0000_0000);  // Unmapped: error, data 0
    chk(pe(0, 0, 0));
    // Every port and drive code, configured while forced off
    for (int i = 0; i < 8; i++)
    begin
      c = {i[0], rs[0], i[1:0], i[2:0]};
      fon <= 1'b0;
      i_link.send(8'h44, 48, fr(c), i[1] ^ i[0]);
      rs = lfsr(rs);
      chk(pe(c, 0, 0));
      apb(0, 12'h004, 0, st(c, 2));
      fon <= 1'b1;
      chk(pe(c, 0, 1));
    end
    c = 7'h04;  // Four ports, four commons, internal clock
    i_link.send(8'h44, 48, fr(c), 1'b0);
    d = {6{rs}};
    d[9:0] = 10'h241;  // Port levels 1,0,1,1 on the four port bits
    i_link.send(8'h44, 96, d, 1'b1);
    apb(0, 12'h00C, 0, {1'b0, d[31:0]});
    chk(pe(c, 4'hD, 1));
    apb(0, 12'h004, 0, st(c, 1));
    // Lengths one bit short of each legal count
    for (int n = 47; n < 96; n += 48)
    begin
      i_link.send(8'h44, n, fr(7'h7F), 1'b0);
      apb(0, 12'h004, 0, st(c, 3));
    end
    i_link.send(8'h45, 48, fr(7'h7F), 1'b0);
    apb(0, 12'h004, 0, st(c, 3));
    apb(1, 12'h000, 0, 0);  // Receiver closed: frame must be dropped
    i_link.send(8'h44, 48, fr(7'h7F), 1'b0);
    apb(0, 12'h004, 0, st(c, 3));
    apb(0, 12'h000, 0, 33'h0);
    apb(1, 12'h000, 1, 0);
    apb(0, 12'h008, 0, 33'h0_0000_020A);
    chk(pe(c, 4'hD, 1));
    end_of_test();
  end
endmodule : lcd_driver_serial_control_tb
`default_nettype wire
